// ---- include/asbp_defines.vh ----
`ifndef ASBP_DEFINES_VH
`define ASBP_DEFINES_VH

// ==========================================================
// Bus widths
`define ASBP_ADDR_W            19
`define ASBP_DATA_W            8

// ==========================================================
// Clock period and device timing, in ns
`define ASBP_CLK_NS            4
`define ASBP_T_ADDR_VALID_NS   10
`define ASBP_T_DATA_HOLD_NS    3
`define ASBP_T_ADDR_SETUP_NS   7
`define ASBP_T_DATA_SETUP_NS   6
`define ASBP_T_WR_FLOAT_NS     5

// Power-up wait, in us
`define ASBP_T_POWER_US        100

// Device least times round up to whole cycles; the power-up wait divides down
`define ASBP_CYC_UP(ns)        (((ns) + `ASBP_CLK_NS - 1) / `ASBP_CLK_NS)
`define ASBP_RD_CYC            `ASBP_CYC_UP(`ASBP_T_ADDR_VALID_NS)
`define ASBP_AW_CYC            `ASBP_CYC_UP(`ASBP_T_ADDR_SETUP_NS)
`define ASBP_SD_CYC            `ASBP_CYC_UP(`ASBP_T_DATA_SETUP_NS)
`define ASBP_HZ_CYC            `ASBP_CYC_UP(`ASBP_T_WR_FLOAT_NS)
`define ASBP_PWR_CYC           ((`ASBP_T_POWER_US * 1000) / `ASBP_CLK_NS)

// ==========================================================
// Controller states
`define ASBP_ST_PWR            3'h0
`define ASBP_ST_IDLE           3'h1
`define ASBP_ST_RD             3'h2
`define ASBP_ST_WR             3'h3
`define ASBP_ST_END            3'h4

`endif

// ---- rtl/asbp_host.v ----
`timescale 1ns/10ps
`include "asbp_defines.vh"
module asbp_host #(
  parameter PWR_CYC = `ASBP_PWR_CYC
) (
  input  wire                    CLK_I,
  input  wire                    RST_N_I,
  input  wire                    REQ_VALID_I,
  input  wire                    REQ_WRITE_I,
  input  wire [`ASBP_ADDR_W-1:0] REQ_ADDR_I,
  input  wire [`ASBP_DATA_W-1:0] REQ_WDATA_I,
  output wire                    REQ_READY_O,
  output reg                     RSP_VALID_O,
  output reg  [`ASBP_DATA_W-1:0] RSP_RDATA_O,
  output reg  [`ASBP_ADDR_W-1:0] ADDRESS_LINES_O,
  output reg                     CHIP_SEL_N_O,
  output reg                     OUT_EN_N_O,
  output reg                     WRITE_N_O,
  input  wire [`ASBP_DATA_W-1:0] DATA_LINES_I,
  output reg  [`ASBP_DATA_W-1:0] DATA_LINES_O,
  output reg                     DATA_LINES_OE_O
);
  localparam [2:0] ST_PWR  = `ASBP_ST_PWR;
  localparam [2:0] ST_IDLE = `ASBP_ST_IDLE;
  localparam [2:0] ST_RD   = `ASBP_ST_RD;
  localparam [2:0] ST_WR   = `ASBP_ST_WR;
  localparam [2:0] ST_END  = `ASBP_ST_END;
  // Read waits access time, then four edges until stages two and three agree
  localparam integer RD_I   = `ASBP_RD_CYC + 4;
  localparam integer AW_I   = `ASBP_AW_CYC;
  localparam integer SD_I   = `ASBP_SD_CYC;
  localparam integer HZ_I   = `ASBP_HZ_CYC;
  localparam integer PW_I   = PWR_CYC;
  localparam [23:0]  RD_CNT = RD_I[23:0];
  localparam [23:0]  AW_CNT = AW_I[23:0];
  localparam [23:0]  SD_CNT = SD_I[23:0];
  localparam [23:0]  HZ_CNT = HZ_I[23:0];
  // Write pulse covers address and data setup, and float delay plus setup
  localparam [23:0] WR_CNT = (AW_CNT > HZ_CNT + SD_CNT) ? AW_CNT : HZ_CNT + SD_CNT;
  localparam [23:0] PW_CNT = PW_I[23:0];

  // ==========================================================
  // Reset release
  reg rst_s1_r;
  reg rst_n_r;

  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ==========================================================
  // Read data pins come from the memory, outside this clock
  wire [`ASBP_DATA_W-1:0] rd_sync;

  asbp_sync #(
    .W (`ASBP_DATA_W)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n_r),
    .d_i     (DATA_LINES_I),
    .q_o     (rd_sync)
  );

  // ==========================================================
  // Sequencer
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [23:0] cnt_r;
  reg [23:0] cnt_nxt;

  assign REQ_READY_O = (state_r == ST_IDLE);

  always @*
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_PWR:
      begin
        if (cnt_r >= PW_CNT - 24'h1)
        begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 24'h0;
        end
        else
          cnt_nxt = cnt_r + 24'h1;
      end
      ST_IDLE:
      begin
        cnt_nxt = 24'h0;
        if (REQ_VALID_I)
          state_nxt = REQ_WRITE_I ? ST_WR : ST_RD;
      end
      ST_RD:
      begin
        if (cnt_r >= RD_CNT - 24'h1)
          state_nxt = ST_END;
        else
          cnt_nxt = cnt_r + 24'h1;
      end
      ST_WR:
      begin
        if (cnt_r >= WR_CNT - 24'h1)
          state_nxt = ST_END;
        else
          cnt_nxt = cnt_r + 24'h1;
      end
      ST_END:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt   = 24'h0;
      end
      default:
      begin
        state_nxt = ST_PWR;
        cnt_nxt   = 24'h0;
      end
    endcase
  end

  // ==========================================================
  // Pin drive; all memory pins from flip-flops, so no glitches reach the memory
  always @(posedge CLK_I or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r         <= ST_PWR;
      cnt_r           <= 24'h0;
      ADDRESS_LINES_O <= {`ASBP_ADDR_W{1'b0}};
      CHIP_SEL_N_O    <= 1'b1;
      OUT_EN_N_O      <= 1'b1;
      WRITE_N_O       <= 1'b1;
      DATA_LINES_O    <= {`ASBP_DATA_W{1'b0}};
      DATA_LINES_OE_O <= 1'b0;
      RSP_VALID_O     <= 1'b0;
      RSP_RDATA_O     <= {`ASBP_DATA_W{1'b0}};
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      RSP_VALID_O <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (REQ_VALID_I)
          begin
            // Address, select and strobes change together: address valid at select edge
            ADDRESS_LINES_O <= REQ_ADDR_I;
            CHIP_SEL_N_O    <= 1'b0;
            WRITE_N_O       <= ~REQ_WRITE_I;
            // Output enable stays high on writes, so no read data meets ours
            OUT_EN_N_O      <= REQ_WRITE_I;
            DATA_LINES_O    <= REQ_WDATA_I;
            DATA_LINES_OE_O <= REQ_WRITE_I;
          end
        end
        ST_RD:
        begin
          if (cnt_r >= RD_CNT - 24'h1)
          begin
            RSP_RDATA_O  <= rd_sync;
            RSP_VALID_O  <= 1'b1;
            CHIP_SEL_N_O <= 1'b1;
            OUT_EN_N_O   <= 1'b1;
          end
        end
        ST_WR:
        begin
          if (cnt_r >= WR_CNT - 24'h1)
          begin
            // Write strobe alone ends the write; data and address held one more cycle
            WRITE_N_O <= 1'b1;
            RSP_VALID_O <= 1'b1;
          end
        end
        ST_END:
        begin
          CHIP_SEL_N_O    <= 1'b1;
          DATA_LINES_OE_O <= 1'b0;
        end
        default:
        begin
          CHIP_SEL_N_O <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ---- rtl/asbp_sync.v ----
`timescale 1ns/10ps
// ==========================================================
// Three-stage synchroniser; output moves when stages two and three agree
module asbp_sync #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer     k;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (k = 0; k < W; k = k + 1)
        if (s2_r[k] == s3_r[k])
          q_o[k] <= s3_r[k];
    end
  end
endmodule

// ---- tb/asbp_host_assertions.sv ----
`timescale 1ns/10ps
`include "asbp_defines.vh"
// ==========================================================
// Pin protocol checks on the host ports
module asbp_host_assertions #(
  parameter PWR_CYC = 20
) (
  input wire                    CLK_I,
  input wire                    RST_N_I,
  input wire                    REQ_VALID_I,
  input wire                    REQ_WRITE_I,
  input wire                    REQ_READY_O,
  input wire                    RSP_VALID_O,
  input wire [`ASBP_ADDR_W-1:0] ADDRESS_LINES_O,
  input wire                    CHIP_SEL_N_O,
  input wire                    OUT_EN_N_O,
  input wire                    WRITE_N_O,
  input wire [`ASBP_DATA_W-1:0] DATA_LINES_O,
  input wire                    DATA_LINES_OE_O
);
  int pwr_cnt_r;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Saturates so long runs cannot wrap
  always @(posedge CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      pwr_cnt_r <= 0;
    else if (pwr_cnt_r < PWR_CYC)
      pwr_cnt_r <= pwr_cnt_r + 1;
  pwr_wait_a: assert property (!CHIP_SEL_N_O |-> pwr_cnt_r >= PWR_CYC)
    else $error("select before power-up wait");
  rd_strobe_a: assert property (!OUT_EN_N_O |-> WRITE_N_O && !DATA_LINES_OE_O)
    else $error("strobe or data driven during read");
  wr_start_a: assert property ($fell(WRITE_N_O) |-> !CHIP_SEL_N_O && DATA_LINES_OE_O)
    else $error("write strobe without select");
  wr_pulse_a: assert property ($fell(WRITE_N_O) |-> !WRITE_N_O [*4] ##1 WRITE_N_O)
    else $error("write pulse length wrong");
  wr_hold_a: assert property ($fell(WRITE_N_O) |=> ($stable(ADDRESS_LINES_O)
    && $stable(DATA_LINES_O) && !CHIP_SEL_N_O && DATA_LINES_OE_O) [*4])
    else $error("write address or data moved");
  rd_addr_a: assert property (!CHIP_SEL_N_O && !$past(CHIP_SEL_N_O)
    |-> $stable(ADDRESS_LINES_O)) else $error("address moved while selected");
  rd_lat_a: assert property (REQ_VALID_I && REQ_READY_O && !REQ_WRITE_I |-> ##8 RSP_VALID_O)
    else $error("read answer late");
  wr_lat_a: assert property (REQ_VALID_I && REQ_READY_O && REQ_WRITE_I |-> ##5 RSP_VALID_O)
    else $error("write answer late");
  cover property ($rose(OUT_EN_N_O));
  cover property ($rose(WRITE_N_O));
  cover property ($rose(REQ_READY_O));
endmodule

// ---- tb/asbp_sram_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Byte-wide static memory behind the host pins
module asbp_sram_model #(
  parameter T_ACC = 10,
  parameter T_OHA = 3
) (
  input  wire [18:0] addr_i,
  input  wire        cs_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire [7:0]  d_i,
  output wire [7:0]  q_o,
  output wire        q_en_o
);
  logic [7:0] mem [0:524287];
  logic [7:0] rd_r = 8'h00;
  assign q_en_o = !cs_n_i && !oe_n_i && we_n_i;
  assign q_o    = rd_r;
  initial
    for (int i = 0; i < 524288; i++)
      mem[i] = 8'h00;
  always @(cs_n_i or we_n_i or addr_i or d_i)
    if (!cs_n_i && !we_n_i)
      mem[addr_i] = d_i;
  // Old data holds briefly, then garbage until access time, so early sampling shows up
  always @(addr_i or q_en_o)
  begin
    rd_r <= #(T_OHA) ~rd_r;
    rd_r <= #(T_ACC) mem[addr_i];
  end
endmodule

// ---- tb/async_sram_byte_port_tb.sv ----
`timescale 1ns/10ps
`include "asbp_defines.vh"
module async_sram_byte_port_tb;
  localparam PWR_CYC = 20;
  logic                    CLK_I = 0;
  logic                    RST_N_I = 0;
  logic                    REQ_VALID_I = 0;
  logic                    REQ_WRITE_I = 0;
  logic [`ASBP_ADDR_W-1:0] REQ_ADDR_I = 0;
  logic [`ASBP_DATA_W-1:0] REQ_WDATA_I = 0;
  logic [`ASBP_DATA_W-1:0] float_r = 0;
  logic [`ASBP_DATA_W-1:0] q;
  wire                     REQ_READY_O, RSP_VALID_O, CHIP_SEL_N_O, OUT_EN_N_O, WRITE_N_O;
  wire                     DATA_LINES_OE_O, dev_en;
  wire  [`ASBP_DATA_W-1:0] RSP_RDATA_O, DATA_LINES_O, DATA_LINES_I, dev_q;
  wire  [`ASBP_ADDR_W-1:0] ADDRESS_LINES_O;
  int                      n_errors = 0;
  int                      n_tests = 0;
  always #2 CLK_I = ~CLK_I;
  // Undriven bus changes every cycle rather than keeping a stale value
  always @(posedge CLK_I) float_r <= float_r + 8'h5B;
  assign DATA_LINES_I = DATA_LINES_OE_O ? DATA_LINES_O : dev_en ? dev_q : float_r;
  asbp_host #(.PWR_CYC(PWR_CYC)) i_asbp_host (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_WRITE_I(REQ_WRITE_I), .REQ_ADDR_I(REQ_ADDR_I),
    .REQ_WDATA_I(REQ_WDATA_I), .REQ_READY_O(REQ_READY_O), .RSP_VALID_O(RSP_VALID_O),
    .RSP_RDATA_O(RSP_RDATA_O), .ADDRESS_LINES_O(ADDRESS_LINES_O),
    .CHIP_SEL_N_O(CHIP_SEL_N_O), .OUT_EN_N_O(OUT_EN_N_O), .WRITE_N_O(WRITE_N_O),
    .DATA_LINES_I(DATA_LINES_I), .DATA_LINES_O(DATA_LINES_O),
    .DATA_LINES_OE_O(DATA_LINES_OE_O));
  asbp_sram_model i_asbp_sram_model (.addr_i(ADDRESS_LINES_O), .cs_n_i(CHIP_SEL_N_O),
    .oe_n_i(OUT_EN_N_O), .we_n_i(WRITE_N_O), .d_i(DATA_LINES_I), .q_o(dev_q), .q_en_o(dev_en));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task print_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task req(input logic w, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (REQ_READY_O !== 1'b1 && n < 100)
    begin
      @(posedge CLK_I);
      #1 n++;
    end
    REQ_VALID_I = 1;
    REQ_WRITE_I = w;
    REQ_ADDR_I = a;
    REQ_WDATA_I = d;
    @(posedge CLK_I);
    #1 REQ_VALID_I = 0;
    while (RSP_VALID_O !== 1'b1 && n < 150)
    begin
      @(posedge CLK_I);
      #1 n++;
    end
    if (n >= 100)
    begin
      n_errors++;
      print_verdict();
    end
    else
      q = RSP_RDATA_O;
  endtask
  task t_reset;
    @(posedge CLK_I);
    #1 RST_N_I = 0;
    repeat (3)
    begin
      @(posedge CLK_I);
      #1 chk("select in reset", 1, CHIP_SEL_N_O);
    end
    RST_N_I = 1;
    t_power();
    req(0, 19'h12345, 8'h00);
    chk("rdata after reset", 8'h5A, q);
  endtask
  task t_power;
    repeat (PWR_CYC)
    begin
      @(posedge CLK_I);
      #1 chk("ready", 0, REQ_READY_O);
      chk("select", 1, CHIP_SEL_N_O);
    end
  endtask
  task t_bounds;
    req(1, 19'h00000, 8'h3C);
    req(1, 19'h7FFFF, 8'hC3);
    req(0, 19'h00000, 8'h00);
    chk("rdata low", 8'h3C, q);
    req(0, 19'h7FFFF, 8'h00);
    chk("rdata high", 8'hC3, q);
  endtask
  task t_overwrite;
    req(1, 19'h12345, 8'hA5);
    req(1, 19'h12345, 8'h5A);
    req(0, 19'h12345, 8'h00);
    chk("rdata over", 8'h5A, q);
    req(0, 19'h12346, 8'h00);
    chk("rdata unwritten", 8'h00, q);
  endtask
  initial
  begin
    repeat (3) @(posedge CLK_I);
    #1 RST_N_I = 1;
    t_power();
    t_bounds();
    t_overwrite();
    t_reset();
    print_verdict();
  end
endmodule
bind asbp_host asbp_host_assertions #(.PWR_CYC(PWR_CYC)) i_asbp_host_assertions (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_VALID_I(REQ_VALID_I), .REQ_WRITE_I(REQ_WRITE_I),
  .REQ_READY_O(REQ_READY_O), .RSP_VALID_O(RSP_VALID_O), .ADDRESS_LINES_O(ADDRESS_LINES_O),
  .CHIP_SEL_N_O(CHIP_SEL_N_O), .OUT_EN_N_O(OUT_EN_N_O), .WRITE_N_O(WRITE_N_O),
  .DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE_O(DATA_LINES_OE_O));
